// ==== design/cis_pkg.sv ====
/*
 * cis_pkg: register map, field positions, reset values and limits for the
 * current input fault detection and scaling channel.
 * Assumes currents are unsigned integers in microamps and engineering
 * values are signed Q16.16 words.
 */
package cis_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int CUR_W  = 16;
    localparam int ENG_W  = 32;
    localparam int ADDR_W = 8;
    localparam int IRQ_W  = 4;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_LEAD_LIM = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SHRT_LIM = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LOW_SIG  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_SIG = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_LOW_SCL  = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_UPP_SCL  = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_VALUE    = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h28;

    ////////////////////////////////////////////////////////////////////////////
    // reset values (microamps, Q16.16)
    localparam logic [CUR_W-1:0] RST_LEAD_LIM = 16'h03E8;
    localparam logic [CUR_W-1:0] RST_SHRT_LIM = 16'h5208;
    localparam logic [CUR_W-1:0] RST_LOW_SIG  = 16'h0FA0;
    localparam logic [CUR_W-1:0] RST_HIGH_SIG = 16'h4E20;
    localparam logic [ENG_W-1:0] RST_LOW_SCL  = 32'h0004_0000;
    localparam logic [ENG_W-1:0] RST_UPP_SCL  = 32'h0014_0000;
    localparam logic             RST_MON_EN   = 1'b0;
    localparam logic [CUR_W-1:0] MAX_CUR      = 16'h6590;

    ////////////////////////////////////////////////////////////////////////////
    // cyclic status byte bit positions
    localparam int ST_FAULT = 1;
    localparam int ST_CONN  = 2;
    localparam int ST_LEAD  = 4;
    localparam int ST_SHORT = 5;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status bits
    localparam int IRQ_FAULT_ON  = 0;
    localparam int IRQ_FAULT_OFF = 1;
    localparam int IRQ_PARAM_ERR = 2;
    localparam int IRQ_NEW_VALUE = 3;

    typedef enum logic {CIS_IDLE, CIS_DIV} cis_state_t;

endpackage

// ==== design/cis_divider.sv ====
/*
 * cis_divider: iterative restoring unsigned divider, one quotient bit per
 * clock. Assumes the divisor is non-zero and that start is only pulsed
 * while busy is low.
 */
`timescale 1ns/1ps
module cis_divider #(
    parameter int NUM_W = 50,
    parameter int DEN_W = 16
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // request
    input  wire logic             i_start,
    input  wire logic [NUM_W-1:0] i_num,
    input  wire logic [DEN_W-1:0] i_den,
    // answer
    output logic                  o_busy,
    output logic                  o_done,
    output logic      [NUM_W-1:0] o_quot
);

    localparam int CNT_W = $clog2(NUM_W + 1);

    logic [DEN_W-1:0] den;
    logic [DEN_W:0]   rem;
    logic [CNT_W-1:0] cnt;
    wire  [DEN_W:0]   shifted = {rem[DEN_W-1:0], o_quot[NUM_W-1]};
    wire  [DEN_W+1:0] trial   = {1'b0, shifted} - {2'b00, den};
    // no borrow means the divisor fits into the partial remainder
    wire              fits    = ~trial[DEN_W+1];

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_quot <= '0;
            rem    <= '0;
            den    <= '0;
            cnt    <= '0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                o_busy <= 1'b1;
                o_quot <= i_num;
                den    <= i_den;
                rem    <= '0;
                cnt    <= CNT_W'(NUM_W);
            end else if (o_busy) begin
                rem    <= fits ? trial[DEN_W:0] : shifted;
                o_quot <= {o_quot[NUM_W-2:0], fits};
                cnt    <= cnt - 1'b1;
                if (cnt == CNT_W'(1)) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule // cis_divider

// ==== design/cis_top.sv ====
/*
 * cis_top: one analog current input channel. Checks the loop current for
 * lead breakage and short circuit, builds the cyclic status byte, raises
 * the diagnostic alarm and scales the current onto an engineering range.
 * Assumes one sample pulse per conversion, currents in microamps and a
 * simple strobe register port driven by a synchronous master.
 */
// Our own choices: the register addresses and the strobed register port.
// How it works
// - a control bit enables line monitoring; it is off after reset
// - a detected line fault sets its flag to 1 in the cyclic status
// - the fault state also drives a diagnostic alarm output and events
// - current below the lead breakage limit (default 1.0 mA) means lead breakage
// - current above the short limit (default 21.0 mA) means short circuit
// - lead breakage limit not below the short limit is a parameter error
// - the low signal current (default 4 mA) is the zero percent point
// - the high signal current (default 20.0 mA) is the hundred percent point
// - low signal zero, high signal zero or low not below high is an error
// - a 32-bit lower scale value, default 4, starts the range
// - a 32-bit upper scale value, default 20, ends the range
// - the line fault result sits in status bit 2
// - a present lead breakage sits in status bit 4
// - a present short circuit sits in status bit 5
`timescale 1ns/1ps
module cis_top
    import cis_pkg::*;
(
    // clock and reset
    input  wire logic              I_CLOCK,
    input  wire logic              I_RST_N,
    // register port
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [ENG_W-1:0]  I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic      [ENG_W-1:0]  O_RDATA,
    // digitized loop current
    input  wire logic [CUR_W-1:0]  I_SAMPLE,
    input  wire logic              I_SAMPLE_VALID,
    // cyclic process data
    output logic      [ENG_W-1:0]  O_VALUE,
    output logic      [7:0]        O_STATUS,
    output logic                   O_DATA_VALID,
    // alarms
    output logic                   O_DIAG_ALARM,
    output logic                   O_IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // sizes of the scaling arithmetic
    localparam int DIFF_W = CUR_W + 1;
    localparam int SPAN_W = ENG_W + 1;
    localparam int PROD_W = DIFF_W + SPAN_W;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] offs);
        hit = (addr == offs);
    endfunction

    function automatic logic over_range(input logic [CUR_W-1:0] val);
        over_range = (val > MAX_CUR);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic              mon_en;
    logic [CUR_W-1:0]  lead_lim;
    logic [CUR_W-1:0]  shrt_lim;
    logic [CUR_W-1:0]  low_sig;
    logic [CUR_W-1:0]  high_sig;
    logic [ENG_W-1:0]  low_scl;
    logic [ENG_W-1:0]  upp_scl;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [CUR_W-1:0]  cur;
    logic              pend;
    logic              lead_break_flag;
    logic              loop_short_flag;
    logic              connection_fault_flag;
    logic              param_err_q;
    logic              neg;
    logic [ENG_W-1:0]  base;
    cis_state_t        state;

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    // writes to read-only or unmapped offsets match no strobe and are dropped
    wire wr_ctrl  = I_WR && hit(I_ADDR, ADDR_CTRL);
    wire wr_lead  = I_WR && hit(I_ADDR, ADDR_LEAD_LIM);
    wire wr_shrt  = I_WR && hit(I_ADDR, ADDR_SHRT_LIM);
    wire wr_low   = I_WR && hit(I_ADDR, ADDR_LOW_SIG);
    wire wr_high  = I_WR && hit(I_ADDR, ADDR_HIGH_SIG);
    wire wr_lscl  = I_WR && hit(I_ADDR, ADDR_LOW_SCL);
    wire wr_uscl  = I_WR && hit(I_ADDR, ADDR_UPP_SCL);
    wire wr_mask  = I_WR && hit(I_ADDR, ADDR_IRQ_MASK);
    wire rd_istat = I_RD && hit(I_ADDR, ADDR_IRQ_STAT);

    ////////////////////////////////////////////////////////////////////////////
    // parameter validation
    wire lim_bad = (lead_lim >= shrt_lim)
                 || over_range(lead_lim) || over_range(shrt_lim);
    wire scl_bad = (low_sig == '0) || (high_sig == '0)
                 || (low_sig >= high_sig)
                 || over_range(low_sig) || over_range(high_sig);
    wire param_err = lim_bad || scl_bad;

    ////////////////////////////////////////////////////////////////////////////
    // line fault detection on each sample
    // an invalid parameter set keeps the channel out of operation
    wire det_on     = mon_en && !param_err;
    wire next_lead  = det_on && (I_SAMPLE < lead_lim);
    wire next_short = det_on && (I_SAMPLE > shrt_lim);
    wire next_conn  = next_lead || next_short;

    // events fire on the edges of the fault state, not on every faulty sample
    wire fault_on   = I_SAMPLE_VALID && next_conn && !connection_fault_flag;
    wire fault_off  = connection_fault_flag
                    && ((I_SAMPLE_VALID && !next_conn) || !det_on);
    wire perr_rise  = param_err && !param_err_q;

    ////////////////////////////////////////////////////////////////////////////
    // scaling arithmetic
    // numerator is the current offset times the engineering span
    wire signed [DIFF_W-1:0] diff = $signed({1'b0, cur}) - $signed({1'b0, low_sig});
    wire signed [SPAN_W-1:0] span = $signed({upp_scl[ENG_W-1], upp_scl})
                                  - $signed({low_scl[ENG_W-1], low_scl});
    wire signed [PROD_W-1:0] prod = diff * span;
    // divide the magnitude so that the quotient truncates toward zero
    wire        [PROD_W-1:0] mag  = prod[PROD_W-1] ? PROD_W'(-prod) : PROD_W'(prod);
    wire        [CUR_W-1:0]  den  = high_sig - low_sig;

    // den is never zero when start fires: equal points are a parameter error
    wire                     start = (state == CIS_IDLE) && !div_busy && pend && !param_err;
    wire                     div_busy;
    wire                     div_done;
    wire        [PROD_W-1:0] quot;
    wire        [ENG_W-1:0]  q32  = quot[ENG_W-1:0];
    // the result wraps if it does not fit the 32-bit word
    wire        [ENG_W-1:0]  next_value = base + (neg ? ENG_W'(-q32) : q32);

    cis_divider #(
        .NUM_W (PROD_W),
        .DEN_W (CUR_W)
    ) u_div (
        .i_clock (I_CLOCK),
        .i_rst_n (I_RST_N),
        .i_start (start),
        .i_num   (mag),
        .i_den   (den),
        .o_busy  (div_busy),
        .o_done  (div_done),
        .o_quot  (quot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over the clear on read
    wire [IRQ_W-1:0] events;
    assign events[IRQ_FAULT_ON]  = fault_on;
    assign events[IRQ_FAULT_OFF] = fault_off;
    assign events[IRQ_PARAM_ERR] = perr_rise;
    assign events[IRQ_NEW_VALUE] = div_done;
    wire [IRQ_W-1:0] next_irq_stat = (rd_istat ? '0 : irq_stat) | events;

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    wire [7:0] status_byte = O_STATUS;
    wire [ENG_W-1:0] rd_mux =
        hit(I_ADDR, ADDR_CTRL)     ? ENG_W'(mon_en)      :
        hit(I_ADDR, ADDR_LEAD_LIM) ? ENG_W'(lead_lim)    :
        hit(I_ADDR, ADDR_SHRT_LIM) ? ENG_W'(shrt_lim)    :
        hit(I_ADDR, ADDR_LOW_SIG)  ? ENG_W'(low_sig)     :
        hit(I_ADDR, ADDR_HIGH_SIG) ? ENG_W'(high_sig)    :
        hit(I_ADDR, ADDR_LOW_SCL)  ? low_scl             :
        hit(I_ADDR, ADDR_UPP_SCL)  ? upp_scl             :
        hit(I_ADDR, ADDR_VALUE)    ? O_VALUE             :
        hit(I_ADDR, ADDR_STATUS)   ? ENG_W'(status_byte) :
        hit(I_ADDR, ADDR_IRQ_STAT) ? ENG_W'(irq_stat)    :
        hit(I_ADDR, ADDR_IRQ_MASK) ? ENG_W'(irq_mask)    :
                                     '0;

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            mon_en   <= RST_MON_EN;
            lead_lim <= RST_LEAD_LIM;
            shrt_lim <= RST_SHRT_LIM;
            irq_mask <= '0;
        end else begin
            if (wr_ctrl) mon_en <= I_WDATA[0];
            if (wr_lead) lead_lim <= I_WDATA[CUR_W-1:0];
            if (wr_shrt) shrt_lim <= I_WDATA[CUR_W-1:0];
            if (wr_mask) irq_mask <= I_WDATA[IRQ_W-1:0];
        end
    end

    // scaling points
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            low_sig  <= RST_LOW_SIG;
            high_sig <= RST_HIGH_SIG;
            low_scl  <= RST_LOW_SCL;
            upp_scl  <= RST_UPP_SCL;
        end else begin
            if (wr_low)  low_sig  <= I_WDATA[CUR_W-1:0];
            if (wr_high) high_sig <= I_WDATA[CUR_W-1:0];
            if (wr_lscl) low_scl  <= I_WDATA;
            if (wr_uscl) upp_scl  <= I_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and interrupts
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            O_RDATA <= '0;
        end else begin
            O_RDATA <= I_RD ? rd_mux : '0;
        end
    end

    // a mask write reaches the interrupt output one cycle after it lands
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irq_stat <= '0;
            O_IRQ    <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            O_IRQ    <= |(next_irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault flags and cyclic status
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            lead_break_flag       <= 1'b0;
            loop_short_flag       <= 1'b0;
            connection_fault_flag <= 1'b0;
            param_err_q           <= 1'b0;
        end else begin
            param_err_q <= param_err;
            if (!det_on) begin
                lead_break_flag       <= 1'b0;
                loop_short_flag       <= 1'b0;
                connection_fault_flag <= 1'b0;
            end else if (I_SAMPLE_VALID) begin
                lead_break_flag       <= next_lead;
                loop_short_flag       <= next_short;
                connection_fault_flag <= next_conn;
            end
        end
    end

    always_comb begin
        O_STATUS           = 8'h00;
        O_STATUS[ST_FAULT] = param_err_q;
        O_STATUS[ST_CONN]  = connection_fault_flag;
        O_STATUS[ST_LEAD]  = lead_break_flag;
        O_STATUS[ST_SHORT] = loop_short_flag;
    end

    // alarm follows the fault state; it is cleared with monitoring off
    assign O_DIAG_ALARM = connection_fault_flag;

    ////////////////////////////////////////////////////////////////////////////
    // scaling sequence
    // only the newest sample waits; older ones are dropped while dividing
    // base is latched at start so a scale write mid division cannot tear it
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            state        <= CIS_IDLE;
            cur          <= '0;
            pend         <= 1'b0;
            neg          <= 1'b0;
            base         <= '0;
            O_VALUE      <= '0;
            O_DATA_VALID <= 1'b0;
        end else begin
            O_DATA_VALID <= 1'b0;
            if (I_SAMPLE_VALID) begin
                cur  <= I_SAMPLE;
                pend <= 1'b1;
            end else if (start) begin
                pend <= 1'b0;
            end
            unique case (state)
                CIS_IDLE: begin
                    if (start) begin
                        neg   <= prod[PROD_W-1];
                        base  <= low_scl;
                        state <= CIS_DIV;
                    end
                end
                CIS_DIV: begin
                    if (div_done) begin
                        O_VALUE      <= next_value;
                        O_DATA_VALID <= 1'b1;
                        state        <= CIS_IDLE;
                    end
                end
            endcase
        end
    end

endmodule // cis_top

// ==== tb/cis_loop_source.sv ====
/*
 * cis_loop_source: behavioural converter that hands one loop current sample
 * to the channel per request.
 * Assumes requests arrive as one-cycle pulses on the rising clock edge.
 */
`timescale 1ns/1ps
module cis_loop_source
    import cis_pkg::*;
(
    // clock
    input  wire logic             i_clock,
    // request from the bench
    input  wire logic             i_req,
    input  wire logic [CUR_W-1:0] i_ua,
    // sample towards the channel
    output logic      [CUR_W-1:0] o_sample = '0,
    output logic                  o_valid  = 1'b0
);
    ////////////////////////////////////////////////////////////////////////////
    // outside a valid cycle the data are garbage, so invert them to catch
    // a channel that reads stale samples
    always_ff @(posedge i_clock) begin
        o_valid  <= i_req;
        o_sample <= i_req ? i_ua : ~o_sample;
    end
endmodule // cis_loop_source

// ==== tb/cis_top_checker.sv ====
/*
 * cis_top_checker: port level assertions for the current input channel.
 * Assumes it sees only the top module ports through the bind below.
 */
`timescale 1ns/1ps
module cis_top_checker
    import cis_pkg::*;
(
    input wire logic              I_CLOCK,
    input wire logic              I_RST_N,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [ENG_W-1:0]  I_WDATA,
    input wire logic              I_WR,
    input wire logic              I_RD,
    input wire logic [ENG_W-1:0]  O_RDATA,
    input wire logic [CUR_W-1:0]  I_SAMPLE,
    input wire logic              I_SAMPLE_VALID,
    input wire logic [ENG_W-1:0]  O_VALUE,
    input wire logic [7:0]        O_STATUS,
    input wire logic              O_DATA_VALID,
    input wire logic              O_DIAG_ALARM,
    input wire logic              O_IRQ
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    ////////////////////////////////////////////////////////////////////////////
    AST_ALARM_IS_FAULT: assert property (O_DIAG_ALARM == O_STATUS[ST_CONN])
        else $error("alarm differs from line fault bit");
    AST_FAULT_IS_OR: assert property (O_STATUS[ST_CONN] == (O_STATUS[ST_LEAD] | O_STATUS[ST_SHORT]))
        else $error("line fault bit is not lead or short");
    AST_LEAD_SHORT_EXCL: assert property (!(O_STATUS[ST_LEAD] && O_STATUS[ST_SHORT]))
        else $error("lead break and short at once");
    AST_RESERVED_ZERO: assert property (O_STATUS[0] == 1'b0 && O_STATUS[3] == 1'b0 && O_STATUS[7:6] == 2'h0)
        else $error("reserved status bit set");
    AST_FLAGS_FOLLOW_CAUSE: assert property ($stable(O_STATUS[5:2]) || $past(I_SAMPLE_VALID)
        || $past(I_WR) || $past(I_WR, 2))
        else $error("fault flags moved without sample or write");
    AST_RDATA_ONE_CYCLE: assert property (!$past(I_RD) |-> O_RDATA == '0)
        else $error("read data outside its cycle");
    AST_VALUE_HOLDS: assert property (!O_DATA_VALID |-> $stable(O_VALUE))
        else $error("value changed without data valid");
    AST_VALID_SPACED: assert property (O_DATA_VALID |=> !O_DATA_VALID [*8])
        else $error("data valid pulses too close");
endmodule // cis_top_checker

bind cis_top cis_top_checker u_checker (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SAMPLE(I_SAMPLE),
    .I_SAMPLE_VALID(I_SAMPLE_VALID), .O_VALUE(O_VALUE), .O_STATUS(O_STATUS),
    .O_DATA_VALID(O_DATA_VALID), .O_DIAG_ALARM(O_DIAG_ALARM), .O_IRQ(O_IRQ));

// ==== tb/current_input_fault_and_scaling_test.sv ====
/*
 * current_input_fault_and_scaling_test: self-checking bench for cis_top.
 * Assumes the loop source model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module current_input_fault_and_scaling_test
    import cis_pkg::*;
;
    logic              clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, req = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [ENG_W-1:0]  wdata = '0, rdata, value, v;
    logic [CUR_W-1:0]  ua = '0, sample;
    logic              svalid, dvalid, diag, irq;
    logic [7:0]        status;
    int                n_errors = 0, compares = 0, lo, hi, lw, up, cu;
    logic [ADDR_W-1:0] ra [10] = '{ADDR_CTRL, ADDR_LEAD_LIM, ADDR_SHRT_LIM, ADDR_LOW_SIG, ADDR_HIGH_SIG,
                                  ADDR_LOW_SCL, ADDR_UPP_SCL, ADDR_STATUS, ADDR_IRQ_MASK, 8'h2C};
    logic [ENG_W-1:0]  rv [10] = '{32'h0, 32'(RST_LEAD_LIM), 32'(RST_SHRT_LIM), 32'(RST_LOW_SIG),
                                  32'(RST_HIGH_SIG), RST_LOW_SCL, RST_UPP_SCL, 32'h0, 32'h0, 32'h0};
    logic [CUR_W-1:0]  fu [5] = '{16'h5209, 16'h5208, 16'h03E8, 16'h03E7, 16'h01F4};
    logic [7:0]        fs [5] = '{8'h24, 8'h00, 8'h00, 8'h14, 8'h14};
    logic [ADDR_W-1:0] pa [5] = '{ADDR_LEAD_LIM, ADDR_LOW_SIG, ADDR_HIGH_SIG, ADDR_LOW_SIG, ADDR_SHRT_LIM};
    logic [CUR_W-1:0]  pv [5] = '{RST_SHRT_LIM, 16'h0000, 16'h0000, RST_HIGH_SIG, 16'h6591};
    logic [CUR_W-1:0]  pr [5] = '{RST_LEAD_LIM, RST_LOW_SIG, RST_HIGH_SIG, RST_LOW_SIG, RST_SHRT_LIM};

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    cis_top dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_stb),
        .I_RD(rd_stb), .O_RDATA(rdata), .I_SAMPLE(sample), .I_SAMPLE_VALID(svalid), .O_VALUE(value),
        .O_STATUS(status), .O_DATA_VALID(dvalid), .O_DIAG_ALARM(diag), .O_IRQ(irq));
    cis_loop_source src (.i_clock(clk), .i_req(req), .i_ua(ua), .o_sample(sample), .o_valid(svalid));

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [ENG_W-1:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [ENG_W-1:0] d);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    // flags are settled one edge after the source presents the sample
    task automatic smp(input logic [CUR_W-1:0] u);
        @(posedge clk);
        req <= 1'b1;
        ua  <= u;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [ENG_W-1:0] scl(input int c, l, h, lo_e, up_e);
        longint d;
        d = longint'(up_e) - longint'(lo_e);
        return ENG_W'(longint'(lo_e) + (longint'(c - l) * d) / longint'(h - l));
    endfunction
    task automatic scale(input int c, l, h, lo_e, up_e);
        int i;
        smp(CUR_W'(c));
        for (i = 0; i < 200 && dvalid !== 1'b1; i++) settle(1);
        `CHK("data valid", 1'b1, dvalid)
        `CHK("latency", 52, i)
        `CHK("value", scl(c, l, h, lo_e, up_e), value)
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        v = $urandom(32'h855ceb67);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], v);
            `CHK("reset reg", rv[i], v)
        end
        smp(16'h01F4);
        `CHK("status mon off", 8'h00, status)
        wr(ADDR_CTRL, 32'h1);
        smp(16'h01F4);
        `CHK("status lead", 8'h14, status)
        `CHK("alarm", 1'b1, diag)
        settle(2);
        `CHK("irq masked", 1'b0, irq)
        wr(ADDR_IRQ_MASK, 32'h1);
        settle(2);
        `CHK("irq unmasked", 1'b1, irq)
        rd(ADDR_IRQ_STAT, v);
        `CHK("irq fault on", 1'b1, v[IRQ_FAULT_ON])
        settle(2);
        `CHK("irq cleared", 1'b0, irq)
        for (int i = 0; i < 5; i++) begin
            smp(fu[i]);
            `CHK("status fault", fs[i], status)
        end
        wr(ADDR_CTRL, 32'h0);
        settle(2);
        `CHK("status cleared", 8'h00, status)
        `CHK("alarm cleared", 1'b0, diag)
        rd(ADDR_IRQ_STAT, v);
        `CHK("irq fault off", 1'b1, v[IRQ_FAULT_OFF])
        wr(ADDR_CTRL, 32'h1);
        smp(16'h2EE0);
        for (int i = 0; i < 5; i++) begin
            wr(pa[i], 32'(pv[i]));
            settle(2);
            smp(16'h01F4);
            `CHK("param error", 8'h02, status)
            wr(pa[i], 32'(pr[i]));
            settle(2);
            `CHK("param ok", 8'h00, status)
        end
        wr(ADDR_CTRL, 32'h0);
        settle(120);
        rd(ADDR_IRQ_STAT, v);
        `CHK("irq param error", 1'b1, v[IRQ_PARAM_ERR])
        `CHK("irq new value", 1'b1, v[IRQ_NEW_VALUE])
        foreach (fu[i]) scale(int'(fu[i]) + 4000, 4000, 20000, 32'h0004_0000, 32'h0014_0000);
        for (int k = 0; k < 6; k++) begin
            lo = 1 + $urandom % 12000;
            hi = lo + 1 + $urandom % (25999 - lo);
            lw = int'($urandom % 32'h0200_0000) - 32'h0100_0000;
            up = int'($urandom % 32'h0200_0000) - 32'h0100_0000;
            cu = (k == 0) ? lo : (k == 1) ? hi : $urandom % 26001;
            wr(ADDR_LOW_SIG, 32'(lo));
            wr(ADDR_HIGH_SIG, 32'(hi));
            wr(ADDR_LOW_SCL, 32'(lw));
            wr(ADDR_UPP_SCL, 32'(up));
            scale(cu, lo, hi, lw, up);
            rd(ADDR_VALUE, v);
            `CHK("value reg", scl(cu, lo, hi, lw, up), v)
        end
        report_and_stop();
    end
endmodule // current_input_fault_and_scaling_test
